// >>> dv/chan_model.sv
/* Model of the eight UART channels behind the block.
   Assumes the block's channel strobes are one-cycle pulses on its clock. */
`default_nettype none
module chan_model (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [7:0] rd_in,
   input wire logic [7:0] wr_in,
   input wire logic [7:0] rst_in,
   input wire logic [7:0] set_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [31:0] modem_in,
   output logic [7:0] req_out,
   output logic [7:0] delta_out,
   output logic [23:0] code_out,
   output logic [63:0] rdata_out
);
   logic [7:0] req_reg, delta_reg, rd_q_reg; // Requests, modem deltas, delayed reads.
   logic [31:0] modem_q_reg; // Previous modem levels, for change detection.
   logic [7:0] store_reg [8]; // One scratch byte per channel.
   // Requests and deltas clear a cycle after the read, so the read still sees them.
   always_ff @(posedge clk_in) begin
      modem_q_reg <= modem_in;
      rd_q_reg <= rd_in;
      for (int n = 0; n < 8; n++) begin
         if (srst_in || rst_in[n]) begin
            req_reg[n] <= 1'b0;
            delta_reg[n] <= 1'b0;
            store_reg[n] <= 8'h00;
         end else begin
            if (set_in[n]) req_reg[n] <= 1'b1;
            else if (rd_q_reg[n] && addr_in == 4'h2) req_reg[n] <= 1'b0;
            if (modem_in[4*n+:4] != modem_q_reg[4*n+:4]) delta_reg[n] <= 1'b1;
            else if (rd_q_reg[n] && addr_in == 4'h6) delta_reg[n] <= 1'b0;
            if (wr_in[n]) store_reg[n] <= wdata_in;
         end
      end
   end
   // Status reads show bit0 high when nothing is pending.
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         rdata_out[8*n+:8] = (addr_in == 4'h2) ? (req_reg[n] ? 8'h04 : 8'h01) : store_reg[n];
         code_out[3*n+:3] = req_reg[n] ? 3'h1 : 3'h0;
      end
   end
   assign req_out = req_reg;
   assign delta_out = delta_reg;
endmodule
`default_nettype wire

// >>> dv/ocfg_monitor.sv
/* Port assertions for the configuration and sleep block.
   Assumes one system clock and the synchronous reset of the block. */
`default_nettype none
module ocfg_monitor (
   input wire logic CLK_SYS_IN,
   input wire logic SRST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] DATA_IN,
   input wire logic CS_N_IN,
   input wire logic RD_N_IN,
   input wire logic DATA_OE_OUT,
   input wire logic INT_OUT,
   input wire logic [7:0] CHAN_INT_REQ_IN,
   input wire logic [7:0] CHAN_MODEM_DELTA_IN,
   input wire logic [7:0] CHAN_RD_OUT,
   input wire logic [7:0] CHAN_WR_OUT,
   input wire logic [3:0] CHAN_ADDR_OUT,
   input wire logic [7:0] CHAN_RESET_OUT,
   input wire logic [7:0] SAMPLE_8X_OUT,
   input wire logic OSC_RUN_OUT,
   input wire logic CLK_OK_OUT
);
   logic [7:0] wake_cnt_reg; // Cycles awake while channel clock use is still held off.
   // Counts the oscillator restart wait so its length can be checked.
   always_ff @(posedge CLK_SYS_IN) begin
      wake_cnt_reg <= (OSC_RUN_OUT && !CLK_OK_OUT) ? wake_cnt_reg + 8'h01 : 8'h00;
   end
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (SRST_IN);
   property p_enter;
      $fell(OSC_RUN_OUT) |-> $past(CHAN_INT_REQ_IN) == 8'h00 && $past(CHAN_MODEM_DELTA_IN) == 8'h00;
   endproperty
   a_enter: assert property (p_enter)
      else $error("sleep entered with work pending");
   property p_clk;
      !OSC_RUN_OUT |-> !CLK_OK_OUT;
   endproperty
   a_clk: assert property (p_clk)
      else $error("clock use allowed while oscillator stopped");
   property p_wint;
      $rose(OSC_RUN_OUT) |-> ##[0:1] INT_OUT;
   endproperty
   a_wint: assert property (p_wint)
      else $error("wake without interrupt");
   property p_hold;
      $rose(CLK_OK_OUT) |-> wake_cnt_reg >= 8'h78 && wake_cnt_reg <= 8'h7F;
   endproperty
   a_hold: assert property (p_hold)
      else $error("clock use resumed at wrong time");
   property p_ret;
      $rose(OSC_RUN_OUT) |-> ##[100:140] CLK_OK_OUT;
   endproperty
   a_ret: assert property (p_ret)
      else $error("clock use never resumed");
   property p_wr;
      CHAN_WR_OUT != 8'h00 |-> !ADDR_IN[7] && (CHAN_WR_OUT == 8'hFF || CHAN_WR_OUT == 8'h01 << ADDR_IN[6:4]);
   endproperty
   a_wr: assert property (p_wr)
      else $error("channel write to wrong lanes");
   property p_rd;
      CHAN_RD_OUT != 8'h00 |-> !ADDR_IN[7] && CHAN_RD_OUT == 8'h01 << ADDR_IN[6:4] && CHAN_ADDR_OUT == ADDR_IN[3:0];
   endproperty
   a_rd: assert property (p_rd)
      else $error("channel read decoded wrongly");
   property p_rst;
      CHAN_RESET_OUT != 8'h00 |-> CHAN_RESET_OUT == DATA_IN && ADDR_IN == ocfg_pkg::OFS_SOFT_RESET ##1 CHAN_RESET_OUT == 8'h00;
   endproperty
   a_rst: assert property (p_rst)
      else $error("soft reset pulse wrong");
   property p_samp;
      $changed(SAMPLE_8X_OUT) |-> !CS_N_IN && ADDR_IN == ocfg_pkg::OFS_SAMPLE_SEL && SAMPLE_8X_OUT == DATA_IN;
   endproperty
   a_samp: assert property (p_samp)
      else $error("sampling select changed without write");
   property p_oe;
      $rose(DATA_OE_OUT) |-> !CS_N_IN && !RD_N_IN;
   endproperty
   a_oe: assert property (p_oe)
      else $error("bus driven without read");
   c_sleep: cover property ($fell(OSC_RUN_OUT));
   c_bcast: cover property (CHAN_WR_OUT == 8'hFF);
   c_rst: cover property (CHAN_RESET_OUT != 8'h00);
endmodule
bind octal_uart_global_config_sleep ocfg_monitor u_ocfg_monitor (.CLK_SYS_IN(CLK_SYS_IN),
   .SRST_IN(SRST_IN), .ADDR_IN(ADDR_IN), .DATA_IN(DATA_IN), .CS_N_IN(CS_N_IN),
   .RD_N_IN(RD_N_IN), .DATA_OE_OUT(DATA_OE_OUT), .INT_OUT(INT_OUT),
   .CHAN_INT_REQ_IN(CHAN_INT_REQ_IN), .CHAN_MODEM_DELTA_IN(CHAN_MODEM_DELTA_IN),
   .CHAN_RD_OUT(CHAN_RD_OUT), .CHAN_WR_OUT(CHAN_WR_OUT), .CHAN_ADDR_OUT(CHAN_ADDR_OUT),
   .CHAN_RESET_OUT(CHAN_RESET_OUT), .SAMPLE_8X_OUT(SAMPLE_8X_OUT),
   .OSC_RUN_OUT(OSC_RUN_OUT), .CLK_OK_OUT(CLK_OK_OUT));
`default_nettype wire

// >>> dv/testbench.sv
/* Self-checking bench for the configuration and sleep block.
   Assumes the channel model answers the block's channel side. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, oe_seen;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rx = 8'hFF, txl = 8'h00, set_req = 8'h00, rdat;
   logic [7:0] wr_seen = 8'h00, rst_seen = 8'h00; // Captured channel pulses.
   logic [31:0] modem = 32'h00000000;
   wire logic [7:0] dout, req, delta, crd, cwr, cwdata, crst, s8x;
   wire logic [3:0] caddr;
   wire logic [23:0] code;
   wire logic [63:0] rdata;
   wire logic oe, int_o, osc, clk_ok;
   int fails = 0, num_checks = 0, cyc = 0;
   logic [7:0] ro_a [9] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h89, 8'h8C, 8'h8D};
   logic [7:0] ro_e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      ocfg_pkg::REVISION_VAL, ocfg_pkg::DEVICE_ID_VAL};
   always #4 clk = ~clk;
   octal_uart_global_config_sleep u_octal_uart_global_config_sleep (.CLK_SYS_IN(clk),
      .SRST_IN(srst), .ADDR_IN(addr), .DATA_IN(wdata), .DATA_OUT(dout), .DATA_OE_OUT(oe),
      .CS_N_IN(cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n), .INT_OUT(int_o), .RX_IN(rx),
      .MODEM_IN(modem), .TMRCK_IN(1'b0), .CHAN_INT_REQ_IN(req), .CHAN_INT_CODE_IN(code),
      .CHAN_MODEM_DELTA_IN(delta), .CHAN_TX_LOAD_IN(txl), .CHAN_RDATA_IN(rdata),
      .CHAN_RD_OUT(crd), .CHAN_WR_OUT(cwr), .CHAN_ADDR_OUT(caddr), .CHAN_WDATA_OUT(cwdata),
      .CHAN_RESET_OUT(crst), .SAMPLE_8X_OUT(s8x), .OSC_RUN_OUT(osc), .CLK_OK_OUT(clk_ok));
   chan_model u_chan_model (.clk_in(clk), .srst_in(srst), .rd_in(crd), .wr_in(cwr),
      .rst_in(crst), .set_in(set_req), .addr_in(caddr), .wdata_in(cwdata), .modem_in(modem),
      .req_out(req), .delta_out(delta), .code_out(code), .rdata_out(rdata));
   // Collects channel pulses; the sequence clears wr_seen off the sampling edge.
   always @(posedge clk) begin
      wr_seen <= wr_seen | cwr;
      rst_seen <= rst_seen | crst;
   end
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         fails++;
         conclude();
      end
   end
   task cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", what, e, g);
         fails++;
      end
   endtask
   // One host access: strobe held long enough to be taken, then idle gap.
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      cs_n = 1'b0;
      rd_n = w;
      wr_n = !w;
      repeat (8) @(posedge clk);
      rdat = dout;
      oe_seen = oe;
      @(negedge clk);
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask
   task chk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      cmp($sformatf("read of %h", a), e, rdat);
      cmp("bus enable", 8'h01, {7'h00, oe_seen});
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) srst = 1'b0;
      // Reset values, then writes that must leave read-only places untouched.
      for (int p = 0; p < 2; p++) begin
         foreach (ro_a[i]) chk(ro_a[i], ro_e[i]);
         foreach (ro_a[i]) bus(1'b1, ro_a[i], 8'hFF);
      end
      bus(1'b1, 8'h86, 8'hA5);
      bus(1'b1, 8'h87, 8'h3C);
      bus(1'b1, 8'h88, 8'hC3);
      chk(8'h86, 8'hA5);
      chk(8'h87, 8'h3C);
      chk(8'h88, 8'hC3);
      cmp("sampling select", 8'hC3, s8x);
      bus(1'b1, 8'h8A, 8'h81);
      cmp("soft reset", 8'h81, rst_seen);
      chk(8'h8A, 8'h00);
      // Broadcast write, then a single-channel write.
      bus(1'b1, 8'h8E, 8'h01);
      chk(8'h8E, 8'h01);
      wr_seen = 8'h00;
      bus(1'b1, 8'h13, 8'h55);
      cmp("write lanes", 8'hFF, wr_seen);
      bus(1'b1, 8'h8E, 8'h00);
      wr_seen = 8'h00;
      bus(1'b1, 8'h35, 8'h66);
      cmp("write lanes", 8'h08, wr_seen);
      cmp("channel offset", 8'h05, {4'h0, caddr});
      chk(8'h35, 8'h66);
      chk(8'h73, 8'h55);
      // Channel requests on channels 2 and 5, code 1 each.
      @(negedge clk) set_req = 8'h24;
      @(negedge clk) set_req = 8'h00;
      chk(8'h80, 8'h24);
      chk(8'h81, 8'h40);
      chk(8'h82, 8'h80);
      chk(8'h83, 8'h00);
      cmp("interrupt", 8'h01, {7'h00, int_o});
      chk(8'h22, 8'h04);
      chk(8'h52, 8'h04);
      chk(8'h80, 8'h00);
      // Sleep needs every enable bit set.
      bus(1'b1, 8'h8B, 8'h7F);
      repeat (20) @(negedge clk);
      cmp("oscillator", 8'h01, {7'h00, osc});
      bus(1'b1, 8'h8B, 8'hFF);
      cmp("oscillator", 8'h00, {7'h00, osc});
      cmp("clock ok", 8'h00, {7'h00, clk_ok});
      @(negedge clk) rx[3] = 1'b0;
      repeat (8) @(negedge clk);
      cmp("oscillator", 8'h01, {7'h00, osc});
      cmp("interrupt", 8'h01, {7'h00, int_o});
      cmp("clock ok", 8'h00, {7'h00, clk_ok});
      rx = 8'hFF;
      repeat (140) @(negedge clk);
      cmp("clock ok", 8'h01, {7'h00, clk_ok});
      chk(8'h80, 8'h08);
      chk(8'h32, 8'h01);
      repeat (10) @(negedge clk);
      cmp("oscillator", 8'h00, {7'h00, osc});
      // Modem wake holds sleep off until the modem status is read.
      @(negedge clk) modem[5] = 1'b1;
      repeat (150) @(negedge clk);
      chk(8'h12, 8'h01);
      repeat (10) @(negedge clk);
      cmp("oscillator", 8'h01, {7'h00, osc});
      chk(8'h16, 8'h55);
      repeat (10) @(negedge clk);
      cmp("oscillator", 8'h00, {7'h00, osc});
      @(negedge clk) txl = 8'h01;
      @(negedge clk) txl = 8'h00;
      repeat (8) @(negedge clk);
      cmp("oscillator", 8'h01, {7'h00, osc});
      cmp("interrupt", 8'h01, {7'h00, int_o});
      repeat (140) @(negedge clk);
      chk(8'h02, 8'h01);
      repeat (10) @(negedge clk);
      @(negedge clk) rx[6] = 1'b0;
      repeat (150) @(negedge clk);
      rx = 8'hFF;
      chk(8'h8B, 8'hFF);
      bus(1'b1, 8'h8B, 8'h00);
      chk(8'h62, 8'h01);
      repeat (20) @(negedge clk);
      cmp("oscillator", 8'h01, {7'h00, osc});
      conclude();
   end
endmodule
`default_nettype wire

// >>> hdl/ocfg_pkg.sv
/*
 * Shared constants of the global configuration and sleep block: the
 * configuration register offsets, timer command codes, reset values and
 * the oscillator restart wait.
 * Assumes one system clock of 125 MHz and an 8-bit host address space.
 */
`default_nettype none
package ocfg_pkg;
   // Clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 8;
   // Oscillator restart time after a wake, in nanoseconds.
   localparam int OSC_START_NS = 1000;
   // Restart wait in cycles, rounded up.
   localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Base of the configuration space.
   localparam logic [7:0] CFG_BASE = 8'h80;
   // Configuration register offsets.
   localparam logic [7:0] OFS_INT_SUMMARY = 8'h80;
   localparam logic [7:0] OFS_INT_CODE_LO = 8'h81;
   localparam logic [7:0] OFS_INT_CODE_MID = 8'h82;
   localparam logic [7:0] OFS_INT_CODE_HI = 8'h83;
   localparam logic [7:0] OFS_TIMER_CMD = 8'h84;
   localparam logic [7:0] OFS_TIMER_RSVD = 8'h85;
   localparam logic [7:0] OFS_TIMER_LO = 8'h86;
   localparam logic [7:0] OFS_TIMER_HI = 8'h87;
   localparam logic [7:0] OFS_SAMPLE_SEL = 8'h88;
   localparam logic [7:0] OFS_RSVD_A = 8'h89;
   localparam logic [7:0] OFS_SOFT_RESET = 8'h8A;
   localparam logic [7:0] OFS_SLEEP_EN = 8'h8B;
   localparam logic [7:0] OFS_REVISION = 8'h8C;
   localparam logic [7:0] OFS_DEVICE_ID = 8'h8D;
   localparam logic [7:0] OFS_BCAST = 8'h8E;
   // Channel register holding the interrupt status, within a channel block.
   localparam logic [3:0] CH_OFS_STATUS = 4'h2;
   // Value that arms sleep; any other value disarms it.
   localparam logic [7:0] SLEEP_ALL = 8'hFF;
   // Reset value of every writable configuration register.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Identification codes; the values are arbitrary.
   localparam logic [7:0] REVISION_VAL = 8'h01;
   localparam logic [7:0] DEVICE_ID_VAL = 8'h5A;
   // Timer interrupt code shown for channel 0.
   localparam logic [2:0] TIMER_CODE = 3'h7;
   // Timer commands.
   localparam logic [3:0] TCMD_INT_ON = 4'h1;
   localparam logic [3:0] TCMD_INT_OFF = 4'h2;
   localparam logic [3:0] TCMD_ONESHOT = 4'h3;
   localparam logic [3:0] TCMD_RETRIG = 4'h4;
   localparam logic [3:0] TCMD_CLK_INT = 4'h5;
   localparam logic [3:0] TCMD_CLK_EXT = 4'h6;
   localparam logic [3:0] TCMD_START = 4'h9;
   localparam logic [3:0] TCMD_STOP = 4'hA;
   localparam logic [3:0] TCMD_RESET = 4'hB;
endpackage
`default_nettype wire

// >>> hdl/octal_uart_global_config_sleep.sv
/*
 * Global configuration registers, channel address decode and sleep with
 * automatic wake of an eight-channel UART.
 * Assumes the host strobes are asynchronous pins with address and data
 * held steady for the whole strobe, and that the channel logic runs on
 * the same clock and answers reads combinationally from CHAN_ADDR_OUT.
 */
`default_nettype none
module octal_uart_global_config_sleep (
   input wire logic CLK_SYS_IN, // System clock.
   input wire logic SRST_IN, // Synchronous reset, active high.
   input wire logic [7:0] ADDR_IN, // Host address lines.
   input wire logic [7:0] DATA_IN, // Host data bus, input side.
   output logic [7:0] DATA_OUT, // Host data bus, output side.
   output logic DATA_OE_OUT, // High while the data bus is driven.
   input wire logic CS_N_IN, // Chip select, active low.
   input wire logic RD_N_IN, // Read strobe, active low.
   input wire logic WR_N_IN, // Write strobe, active low.
   output logic INT_OUT, // Device interrupt, active high.
   input wire logic [7:0] RX_IN, // Receive data pins.
   input wire logic [31:0] MODEM_IN, // Modem inputs, four per channel.
   input wire logic TMRCK_IN, // External timer clock pin.
   input wire logic [7:0] CHAN_INT_REQ_IN, // Channel service requests.
   input wire logic [23:0] CHAN_INT_CODE_IN, // Channel source codes.
   input wire logic [7:0] CHAN_MODEM_DELTA_IN, // Channel modem delta pending.
   input wire logic [7:0] CHAN_TX_LOAD_IN, // Channel transmit load pulses.
   input wire logic [63:0] CHAN_RDATA_IN, // Channel read data, byte per channel.
   output logic [7:0] CHAN_RD_OUT, // Channel read pulses.
   output logic [7:0] CHAN_WR_OUT, // Channel write pulses.
   output logic [3:0] CHAN_ADDR_OUT, // Register offset within a channel.
   output logic [7:0] CHAN_WDATA_OUT, // Channel write data.
   output logic [7:0] CHAN_RESET_OUT, // Channel soft reset pulses.
   output logic [7:0] SAMPLE_8X_OUT, // High selects 8X sampling.
   output logic OSC_RUN_OUT, // High while the crystal oscillator runs.
   output logic CLK_OK_OUT // High when channels may use the clock.
);
   // Whole state of the block.
   typedef struct packed {
      logic [7:0] rx_s1, rx_s2, rx_s3; // Receive pin synchroniser.
      logic [7:0] rx_st; // Accepted receive level.
      logic [31:0] md_s1, md_s2, md_s3; // Modem pin synchroniser.
      logic [31:0] md_st; // Accepted modem level.
      logic [2:0] bus_s1, bus_s2, bus_s3; // Strobe synchroniser: cs, rd, wr.
      logic rd_act; // Accepted read strobe state.
      logic wr_act; // Accepted write strobe state.
      logic tk_s1, tk_s2, tk_s3; // Timer clock synchroniser.
      logic tk_st; // Accepted timer clock level.
      logic [7:0] dout; // Read data.
      logic doe; // Data bus enable.
      logic rd_pend; // Channel read awaiting data.
      logic [2:0] rd_chan; // Channel being read.
      logic [7:0] chan_rd; // Channel read pulses.
      logic [7:0] chan_wr; // Channel write pulses.
      logic [3:0] chan_addr; // Channel register offset.
      logic [7:0] chan_wdata; // Channel write data.
      logic [7:0] chan_rst; // Soft reset pulses.
      logic [7:0] sample8x; // Sampling select.
      logic [7:0] sleep_en; // Sleep enables.
      logic bcast; // Broadcast write enable.
      logic tmr_ien; // Timer interrupt enable.
      logic tmr_oneshot; // One-shot mode.
      logic tmr_ext; // External clock source.
      logic tmr_run; // Timer running.
      logic tmr_irq; // Timer interrupt pending.
      logic [15:0] tmr_reload; // Reload value.
      logic [15:0] tmr_cnt; // Live count.
      logic asleep; // Oscillator stopped.
      logic [7:0] osc_wait; // Restart wait counter.
      logic clk_ok; // Clock usable.
      logic [7:0] wake; // Special wake interrupt per channel.
      logic int_out; // Device interrupt.
   } state_s;

   state_s st_reg; // Registered state.
   state_s st_next; // Next state.

   // Restart counter load value, cast to eight bits.
   localparam logic [7:0] OSC_LOAD = 8'(ocfg_pkg::OSC_START_CYC);

   // Returns true when a pin synchroniser's last two stages agree.
   function automatic logic [31:0] agree(input logic [31:0] a, input logic [31:0] b);
      agree = ~(a ^ b);
   endfunction

   logic [31:0] md_agree; // Modem synchroniser stages two and three agree.
   logic [7:0] summary; // Interrupt summary as read.
   logic [23:0] codes; // Packed source codes as read.
   logic [7:0] rx_fall; // Start bit edges.
   logic [7:0] md_chg; // Modem level changes per channel.
   logic [7:0] wake_ev; // Any wake event per channel.
   logic rd_go; // Host read begins.
   logic wr_go; // Host write begins.
   logic cfg_hit; // Address is in the configuration space.
   logic [2:0] ch_idx; // Channel selected by the address.
   logic tmr_tick; // One timer count step.
   logic tmr_done; // Timer reached the end.
   logic can_sleep; // All sleep conditions met.

   // Decode, events and status views that feed the next-state logic.
   always_comb begin
      summary = CHAN_INT_REQ_IN | st_reg.wake;
      summary[0] = summary[0] | st_reg.tmr_irq;
      codes = CHAN_INT_CODE_IN;
      // The timer shows up only on channel 0, below any channel source.
      if (st_reg.tmr_irq && (CHAN_INT_CODE_IN[2:0] == 3'h0)) begin
         codes[2:0] = ocfg_pkg::TIMER_CODE;
      end
      rx_fall = st_reg.rx_st & ~st_reg.rx_s2 & ~st_reg.rx_s3;
      md_agree = agree(st_reg.md_s2, st_reg.md_s3);
      for (int n = 0; n < 8; n++) begin
         md_chg[n] = |((st_reg.md_st[4*n +: 4] ^ st_reg.md_s2[4*n +: 4]) & md_agree[4*n +: 4]);
      end
      wake_ev = rx_fall | md_chg | CHAN_TX_LOAD_IN;
      rd_go = !st_reg.rd_act && st_reg.bus_s2[1] && st_reg.bus_s3[1];
      wr_go = !st_reg.wr_act && st_reg.bus_s2[2] && st_reg.bus_s3[2];
      cfg_hit = ADDR_IN[7];
      ch_idx = ADDR_IN[6:4];
      tmr_tick = st_reg.tmr_ext ? (!st_reg.tk_st && st_reg.tk_s2 && st_reg.tk_s3) : 1'b1;
      tmr_done = st_reg.tmr_run && tmr_tick && (st_reg.tmr_cnt <= 16'h0001);
      can_sleep = (summary == 8'h00)
         && (st_reg.sleep_en == ocfg_pkg::SLEEP_ALL)
         && (CHAN_MODEM_DELTA_IN == 8'h00)
         && (st_reg.rx_st == 8'hFF) && (wake_ev == 8'h00);
   end

   // Next state: synchronisers, bus access, timer and sleep control.
   always_comb begin
      st_next = st_reg;
      // Pin synchronisers; a level is accepted once stages two and three agree.
      st_next.rx_s1 = RX_IN;
      st_next.rx_s2 = st_reg.rx_s1;
      st_next.rx_s3 = st_reg.rx_s2;
      st_next.rx_st = (st_reg.rx_s2 & st_reg.rx_s3) | (st_reg.rx_st & (st_reg.rx_s2 ^ st_reg.rx_s3));
      st_next.md_s1 = MODEM_IN;
      st_next.md_s2 = st_reg.md_s1;
      st_next.md_s3 = st_reg.md_s2;
      st_next.md_st = (st_reg.md_s2 & agree(st_reg.md_s2, st_reg.md_s3))
         | (st_reg.md_st & ~agree(st_reg.md_s2, st_reg.md_s3));
      st_next.bus_s1 = {~WR_N_IN & ~CS_N_IN, ~RD_N_IN & ~CS_N_IN, ~CS_N_IN};
      st_next.bus_s2 = st_reg.bus_s1;
      st_next.bus_s3 = st_reg.bus_s2;
      st_next.tk_s1 = TMRCK_IN;
      st_next.tk_s2 = st_reg.tk_s1;
      st_next.tk_s3 = st_reg.tk_s2;
      if (st_reg.tk_s2 == st_reg.tk_s3) begin
         st_next.tk_st = st_reg.tk_s2;
      end
      // Strobe states follow the synchronised strobes once they agree.
      if (st_reg.bus_s2[1] == st_reg.bus_s3[1]) begin
         st_next.rd_act = st_reg.bus_s2[1];
      end
      if (st_reg.bus_s2[2] == st_reg.bus_s3[2]) begin
         st_next.wr_act = st_reg.bus_s2[2];
      end
      // The data bus is driven while the read strobe stays accepted.
      st_next.doe = st_next.rd_act;
      // Pulses last one cycle.
      st_next.chan_rd = 8'h00;
      st_next.chan_wr = 8'h00;
      st_next.chan_rst = 8'h00;
      st_next.rd_pend = 1'b0;

      // Timer counting.
      if (tmr_done) begin
         st_next.tmr_irq = st_reg.tmr_ien;
         st_next.tmr_cnt = st_reg.tmr_reload;
         st_next.tmr_run = !st_reg.tmr_oneshot;
      end else if (st_reg.tmr_run && tmr_tick) begin
         st_next.tmr_cnt = st_reg.tmr_cnt - 16'h0001;
      end

      // Channel read data is taken in the same cycle as the read pulse, since rd_pend is set with it.
      if (st_reg.rd_pend) begin
         st_next.dout = CHAN_RDATA_IN[8*st_reg.rd_chan +: 8];
      end

      // Host read.
      if (rd_go) begin
         if (cfg_hit) begin
            unique case (ADDR_IN)
               ocfg_pkg::OFS_INT_SUMMARY: st_next.dout = summary;
               ocfg_pkg::OFS_INT_CODE_LO: st_next.dout = codes[7:0];
               ocfg_pkg::OFS_INT_CODE_MID: st_next.dout = codes[15:8];
               ocfg_pkg::OFS_INT_CODE_HI: st_next.dout = codes[23:16];
               ocfg_pkg::OFS_TIMER_CMD: begin
                  // Reading reports and clears a pending timer interrupt.
                  st_next.dout = {7'h00, st_reg.tmr_irq};
                  st_next.tmr_irq = tmr_done && st_reg.tmr_ien;
               end
               ocfg_pkg::OFS_TIMER_LO: st_next.dout = st_reg.tmr_reload[7:0];
               ocfg_pkg::OFS_TIMER_HI: st_next.dout = st_reg.tmr_reload[15:8];
               ocfg_pkg::OFS_SAMPLE_SEL: st_next.dout = st_reg.sample8x;
               ocfg_pkg::OFS_SLEEP_EN: st_next.dout = st_reg.sleep_en;
               ocfg_pkg::OFS_REVISION: st_next.dout = ocfg_pkg::REVISION_VAL;
               ocfg_pkg::OFS_DEVICE_ID: st_next.dout = ocfg_pkg::DEVICE_ID_VAL;
               ocfg_pkg::OFS_BCAST: st_next.dout = {7'h00, st_reg.bcast};
               // Reserved, write-only and unused locations read as zero.
               default: st_next.dout = 8'h00;
            endcase
         end else begin
            // Channel space: pass the read on and collect the data next cycle.
            st_next.chan_rd[ch_idx] = 1'b1;
            st_next.chan_addr = ADDR_IN[3:0];
            st_next.rd_pend = 1'b1;
            st_next.rd_chan = ch_idx;
            // A status read clears that channel's special wake interrupt.
            if (ADDR_IN[3:0] == ocfg_pkg::CH_OFS_STATUS) begin
               st_next.wake[ch_idx] = 1'b0;
            end
         end
      end

      // Host write.
      if (wr_go) begin
         if (cfg_hit) begin
            unique case (ADDR_IN)
               ocfg_pkg::OFS_TIMER_CMD: begin
                  unique case (DATA_IN[3:0])
                     ocfg_pkg::TCMD_INT_ON: st_next.tmr_ien = 1'b1;
                     ocfg_pkg::TCMD_INT_OFF: st_next.tmr_ien = 1'b0;
                     ocfg_pkg::TCMD_ONESHOT: st_next.tmr_oneshot = 1'b1;
                     ocfg_pkg::TCMD_RETRIG: st_next.tmr_oneshot = 1'b0;
                     ocfg_pkg::TCMD_CLK_INT: st_next.tmr_ext = 1'b0;
                     ocfg_pkg::TCMD_CLK_EXT: st_next.tmr_ext = 1'b1;
                     ocfg_pkg::TCMD_START: begin
                        st_next.tmr_run = 1'b1;
                        st_next.tmr_cnt = st_reg.tmr_reload;
                     end
                     ocfg_pkg::TCMD_STOP: st_next.tmr_run = 1'b0;
                     ocfg_pkg::TCMD_RESET: begin
                        st_next.tmr_run = 1'b0;
                        st_next.tmr_cnt = st_reg.tmr_reload;
                     end
                     // Reserved commands do nothing.
                     default: st_next.tmr_run = st_next.tmr_run;
                  endcase
               end
               ocfg_pkg::OFS_TIMER_LO: st_next.tmr_reload[7:0] = DATA_IN;
               ocfg_pkg::OFS_TIMER_HI: st_next.tmr_reload[15:8] = DATA_IN;
               ocfg_pkg::OFS_SAMPLE_SEL: st_next.sample8x = DATA_IN;
               ocfg_pkg::OFS_SOFT_RESET: st_next.chan_rst = DATA_IN;
               ocfg_pkg::OFS_SLEEP_EN: st_next.sleep_en = DATA_IN;
               ocfg_pkg::OFS_BCAST: st_next.bcast = DATA_IN[0];
               // Read-only and reserved locations ignore writes.
               default: st_next.bcast = st_next.bcast;
            endcase
         end else begin
            // Channel space write, to one channel or all of them.
            if (st_reg.bcast) begin
               st_next.chan_wr = 8'hFF;
            end else begin
               st_next.chan_wr[ch_idx] = 1'b1;
            end
            st_next.chan_addr = ADDR_IN[3:0];
            st_next.chan_wdata = DATA_IN;
         end
      end

      // Sleep entry and exit.
      if (st_reg.asleep) begin
         if (wake_ev != 8'h00) begin
            st_next.asleep = 1'b0;
            st_next.wake = st_next.wake | wake_ev;
            st_next.osc_wait = OSC_LOAD;
         end
      end else if (can_sleep && st_reg.clk_ok) begin
         st_next.asleep = 1'b1;
         st_next.clk_ok = 1'b0;
      end
      // Channels get the clock back once the restart wait is over.
      if (!st_reg.asleep && !st_reg.clk_ok) begin
         if (st_reg.osc_wait <= 8'h01) begin
            st_next.clk_ok = 1'b1;
            st_next.osc_wait = 8'h00;
         end else begin
            st_next.osc_wait = st_reg.osc_wait - 8'h01;
         end
      end
      st_next.int_out = (summary != 8'h00) || (st_next.wake != 8'h00);
   end

   // State register with synchronous reset.
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         st_reg <= '0;
         st_reg.rx_st <= 8'hFF;
         st_reg.rx_s1 <= 8'hFF;
         st_reg.rx_s2 <= 8'hFF;
         st_reg.rx_s3 <= 8'hFF;
         st_reg.sleep_en <= ocfg_pkg::RESET_BYTE;
         st_reg.sample8x <= ocfg_pkg::RESET_BYTE;
         st_reg.clk_ok <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come from state flip-flops, OSC_RUN_OUT through an inverter.
   assign DATA_OUT = st_reg.dout;
   assign DATA_OE_OUT = st_reg.doe;
   assign INT_OUT = st_reg.int_out;
   assign CHAN_RD_OUT = st_reg.chan_rd;
   assign CHAN_WR_OUT = st_reg.chan_wr;
   assign CHAN_ADDR_OUT = st_reg.chan_addr;
   assign CHAN_WDATA_OUT = st_reg.chan_wdata;
   assign CHAN_RESET_OUT = st_reg.chan_rst;
   assign SAMPLE_8X_OUT = st_reg.sample8x;
   assign OSC_RUN_OUT = ~st_reg.asleep;
   assign CLK_OK_OUT = st_reg.clk_ok;
endmodule
`default_nettype wire
